// File: fsw_defines.vh
// Constants for the flash status register and write protection block
`ifndef FSW_DEFINES_VH
`define FSW_DEFINES_VH

// Clock period and timing in ns; cycle counts derived, least times rounded up
`define FSW_CLK_NS 5
`define FSW_PUW_NS 10000
`define FSW_PUW_CYC ((`FSW_PUW_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)
`define FSW_TW_NS 5000
`define FSW_TW_CYC ((`FSW_TW_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)

// Command bytes
`define FSW_CMD_WREN 8'h06
`define FSW_CMD_VWREN 8'h50
`define FSW_CMD_WRDI 8'h04
`define FSW_CMD_WRSR 8'h01
`define FSW_CMD_RDSR1 8'h05
`define FSW_CMD_RDSR2 8'h35
`define FSW_CMD_RDSR3 8'h15
`define FSW_CMD_SUSP 8'h75
`define FSW_CMD_RESUME 8'h7A
`define FSW_CMD_PD 8'hB9
`define FSW_CMD_RELPD 8'hAB
`define FSW_CMD_RSTEN 8'h66
`define FSW_CMD_RST 8'h99
`define FSW_CMD_PP 8'h02
`define FSW_CMD_SE 8'h20
`define FSW_CMD_BE 8'hD8
`define FSW_CMD_CE 8'hC7

// Field positions
`define FSW_S1_BUSY 0
`define FSW_S1_WEL 1
`define FSW_S1_STATUS_LOCK_LO 7
`define FSW_S2_STATUS_LOCK_HI 0
`define FSW_S2_QE 1
`define FSW_S2_LB_LO 3
`define FSW_S2_LB_HI 5
`define FSW_S2_CMP 6
`define FSW_S2_SUS 7
`define FSW_S3_WPS 2
`define FSW_S3_HFQ 4
`define FSW_S3_DRV_LO 5
`define FSW_S3_DRV_HI 6
`define FSW_S3_SHARED_PIN_FUNCTION_SEL 7

// Writable masks of protectable configuration bits
`define FSW_S1_WMASK 8'hFC
`define FSW_S2_WMASK 8'h43
`define FSW_S3_WMASK 8'hF4

// Reset values
`define FSW_S1_RESET 8'h00
`define FSW_S2_RESET 8'h00
`define FSW_S3_RESET 8'h10
`define FSW_LB_RESET 3'h0

`endif

// File: fsw_status_protect.v
// Status register configuration and write protection gating of a serial NOR flash
// Behaviour
// RULE1 - Complement bit inverts the selected protected region
// RULE2 - Two non-volatile status protect bits select method
// RULE3 - Protect bits 00: pin ignored, write when enabled
// RULE4 - Protect bits 01: pin low refuses status writes
// RULE5 - Protect bits 10: locked until power or reset
// RULE6 - Protect bits 11: status writes refused forever
// RULE7 - Busy, enable latch, suspend are read-only
// RULE8 - Write enable then status write updates non-volatile
// RULE9 - Volatile enable then status write updates volatile
// RULE10 - Security lock bits have no volatile copy
// RULE11 - Suspend sets suspend flag, resume clears it
// RULE12 - Security lock bits set once, never clear
// RULE13 - Quad enable turns protect and hold pins off
// RULE14 - Shared pin is hold or reset by select
// RULE15 - Drive field selects 50, 25, 75, 100 percent
// RULE16 - High frequency enable defaults to one
// RULE17 - Scheme select picks region bits or locks
// RULE18 - Per-block locks set to one after reset
// RULE19 - Write commands need whole bytes before deselect
// RULE20 - Power-up delay refuses all write commands
// RULE21 - Enable latch clear at power-up, before writes
// RULE22 - Deep power-down ignores all but release
// RULE23 - Busy set during writes; only status reads; code also accepts suspend while an array operation is busy
// RULE24 - Enable latch set and cleared by commands
// RULE25 - Top/bottom bit counts protect from top or bottom
// RULE26 - Protected target makes program or erase ignored
// RULE27 - Refused status write changes nothing, no busy
// RULE28 - Status reads show currently effective values
`timescale 1ns/10ps
`include "fsw_defines.vh"

module fsw_status_protect (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Serial link pins
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_mosi,
  input wire i_wp_n,
  output reg o_miso,
  output reg o_miso_oe_n,
  // Array engine handshake
  input wire i_target_protected,
  input wire i_array_done,
  output reg o_array_start,
  output reg [7:0] o_array_cmd,
  output reg [23:0] o_array_addr,
  output reg o_lock_init,
  // Effective status and configuration
  output reg [7:0] o_status_one,
  output reg [7:0] o_status_two,
  output reg [7:0] o_status_three,
  output reg o_busy,
  output reg o_deep_power_down,
  output reg o_complement_protect,
  output reg o_top_bottom_select,
  output reg o_protect_scheme_sel,
  output reg o_quad_enable,
  output reg o_wp_pin_active,
  output reg o_pin_is_hold,
  output reg o_pin_is_reset,
  output reg [6:0] o_drive_pct,
  output reg o_quad_high_freq_enable,
  output reg [2:0] o_secreg_lock
);

  // Full-width counts, cut on purpose to the 16-bit timers
  localparam [31:0] PUW_FULL = `FSW_PUW_CYC;
  localparam [31:0] TW_FULL = `FSW_TW_CYC;
  localparam [15:0] PUW_CYC = PUW_FULL[15:0];
  localparam [15:0] TW_CYC = TW_FULL[15:0];

  // Merges written data into the writable bits of a register
  function [7:0] merge;
    input [7:0] old;
    input [7:0] data;
    input [7:0] mask;
    begin
      merge = (old & ~mask) | (data & mask);
    end
  endfunction

  // Picks the status register a read command returns
  function [7:0] status_sel;
    input [7:0] c;
    input [7:0] s1;
    input [7:0] s2;
    input [7:0] s3;
    begin
      if (c == `FSW_CMD_RDSR2) begin
        status_sel = s2;
      end else if (c == `FSW_CMD_RDSR3) begin
        status_sel = s3;
      end else begin
        status_sel = s1;
      end
    end
  endfunction

  // Pin synchronisers and edge history
  reg cs_m, cs_s, cs_p, ck_m, ck_s, ck_p, di_m, di_s, wp_m, wp_s;
  // Frame decoding
  reg [2:0] bit_q;
  reg [2:0] byte_q;
  reg [7:0] sh_q;
  reg [7:0] cmd_q;
  reg [23:0] wd_q;
  reg [7:0] out_q;
  reg rd_q;
  // Status storage
  reg [7:0] nv1_q, nv2_q, nv3_q, vol1_q, vol2_q, vol3_q;
  reg [2:0] lb_q;
  reg wel_q, vwel_q, sus_q, dpd_q, arr_busy_q, tw_busy_q, rst_en_q, load_q;
  reg [15:0] pu_cnt_q;
  reg [15:0] tw_cnt_q;

  wire ck_rise = ck_s & ~ck_p & ~cs_s;
  wire ck_fall = ~ck_s & ck_p & ~cs_s;
  wire cs_end = cs_s & ~cs_p;
  wire byte_done = ck_rise & (bit_q == 3'h7);
  wire [7:0] byte_val = {sh_q[6:0], di_s};
  wire busy = arr_busy_q | tw_busy_q;
  wire pu_lock = (pu_cnt_q != PUW_CYC);
  wire boundary = (bit_q == 3'h0) & (byte_q != 3'h0);
  wire [1:0] srp = {vol2_q[`FSW_S2_STATUS_LOCK_HI], vol1_q[`FSW_S1_STATUS_LOCK_LO]};
  wire qe = vol2_q[`FSW_S2_QE];
  wire wp_high = wp_s | qe;
  wire sr_open = (srp == 2'b00) | ((srp == 2'b01) & wp_high);
  wire [2:0] nbytes = byte_q - 3'h1;
  wire [7:0] d1 = (nbytes == 3'h1) ? wd_q[7:0] : ((nbytes == 3'h2) ? wd_q[15:8] : wd_q[23:16]);
  wire [7:0] d2 = (nbytes == 3'h2) ? wd_q[7:0] : wd_q[15:8];
  wire [7:0] d3 = wd_q[7:0];
  wire has2 = (nbytes >= 3'h2);
  wire has3 = (nbytes >= 3'h3);
  wire is_arr = (cmd_q == `FSW_CMD_PP) | (cmd_q == `FSW_CMD_SE) | (cmd_q == `FSW_CMD_BE);
  wire arr_len_ok = is_arr ? (byte_q >= 3'h4) : (cmd_q == `FSW_CMD_CE);
  wire susp_ok = (cmd_q == `FSW_CMD_SUSP) & arr_busy_q & ~sus_q;
  wire blocked = dpd_q ? (cmd_q != `FSW_CMD_RELPD) : (busy & ~susp_ok); // [RULE22] [RULE23]

  // Effective status: volatile copy, with busy, enable latch, suspend and security lock bits taken live
  wire [7:0] eff1 = {vol1_q[7:2], wel_q, busy}; // [RULE28] [RULE7]
  wire [7:0] eff2 = {sus_q, vol2_q[`FSW_S2_CMP], lb_q, 1'b0, vol2_q[1:0]};
  wire [7:0] eff3 = vol3_q & `FSW_S3_WMASK;

  // Two flip-flop synchronisers on every pin
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      {cs_m, cs_s, cs_p} <= 3'h7;
      {ck_m, ck_s, ck_p} <= 3'h0;
      {di_m, di_s, wp_m, wp_s} <= 4'h0;
    end else begin
      cs_m <= i_cs_n;
      cs_s <= cs_m;
      cs_p <= cs_s;
      ck_m <= i_sclk;
      ck_s <= ck_m;
      ck_p <= ck_s;
      di_m <= i_mosi;
      di_s <= di_m;
      wp_m <= i_wp_n;
      wp_s <= wp_m;
    end
  end

  // Byte assembly, command capture and status read-out
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      bit_q <= 3'h0;
      byte_q <= 3'h0;
      sh_q <= 8'h00;
      cmd_q <= 8'h00;
      wd_q <= 24'h000000;
      out_q <= 8'h00;
      rd_q <= 1'b0;
      o_miso <= 1'b0;
      o_miso_oe_n <= 1'b1;
    end else begin
      o_miso_oe_n <= ~rd_q;
      if (cs_s) begin
        bit_q <= 3'h0;
        byte_q <= 3'h0;
        rd_q <= 1'b0;
      end else if (ck_rise) begin
        sh_q <= byte_val;
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          if (byte_q != 3'h7) begin
            byte_q <= byte_q + 3'h1;
          end
          if (byte_q == 3'h0) begin
            cmd_q <= byte_val;
            rd_q <= ~dpd_q & ((byte_val == `FSW_CMD_RDSR1) | (byte_val == `FSW_CMD_RDSR2)
                    | (byte_val == `FSW_CMD_RDSR3));
            out_q <= status_sel(byte_val, eff1, eff2, eff3);
          end else begin
            if (byte_q <= 3'h3) begin
              wd_q <= {wd_q[15:0], byte_val};
            end
            out_q <= status_sel(cmd_q, eff1, eff2, eff3);
          end
        end
      end else if (ck_fall & rd_q) begin
        o_miso <= out_q[7];
        out_q <= {out_q[6:0], out_q[7]};
      end
    end
  end

  // Command execution at deselect, status storage and timers
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      nv1_q <= `FSW_S1_RESET;
      nv2_q <= `FSW_S2_RESET;
      nv3_q <= `FSW_S3_RESET; // [RULE16]
      vol1_q <= `FSW_S1_RESET;
      vol2_q <= `FSW_S2_RESET; // [RULE1] [RULE25]
      vol3_q <= `FSW_S3_RESET;
      lb_q <= `FSW_LB_RESET;
      wel_q <= 1'b0; // [RULE21]
      vwel_q <= 1'b0;
      sus_q <= 1'b0;
      dpd_q <= 1'b0;
      arr_busy_q <= 1'b0;
      tw_busy_q <= 1'b0;
      rst_en_q <= 1'b0;
      load_q <= 1'b1;
      pu_cnt_q <= 16'h0000;
      tw_cnt_q <= 16'h0000;
      o_array_start <= 1'b0;
      o_array_cmd <= 8'h00;
      o_array_addr <= 24'h000000;
      o_lock_init <= 1'b0;
    end else begin
      o_array_start <= 1'b0;
      o_lock_init <= load_q; // [RULE18]
      load_q <= 1'b0;
      if (pu_lock) begin
        pu_cnt_q <= pu_cnt_q + 16'h0001; // [RULE20]
      end
      if (tw_busy_q) begin
        tw_cnt_q <= tw_cnt_q + 16'h0001;
        if (tw_cnt_q == TW_CYC - 16'h0001) begin
          tw_busy_q <= 1'b0;
        end
      end
      if (arr_busy_q & i_array_done) begin
        arr_busy_q <= 1'b0;
      end
      // Copy stored bits to effective ones; lock-down state does not survive
      if (load_q) begin
        vol1_q <= nv1_q & ~((nv2_q[`FSW_S2_STATUS_LOCK_HI] & ~nv1_q[`FSW_S1_STATUS_LOCK_LO]) ? 8'h80 : 8'h00); // [RULE5]
        vol2_q <= nv2_q & ~((nv2_q[`FSW_S2_STATUS_LOCK_HI] & ~nv1_q[`FSW_S1_STATUS_LOCK_LO]) ? 8'h01 : 8'h00);
        vol3_q <= nv3_q;
        wel_q <= 1'b0;
        vwel_q <= 1'b0;
        dpd_q <= 1'b0;
      end else if (cs_end) begin
        rst_en_q <= 1'b0;
        if (boundary & ~blocked) begin // [RULE19]
          case (cmd_q)
            `FSW_CMD_WREN: begin
              if (~pu_lock) begin
                wel_q <= 1'b1; // [RULE24]
                vwel_q <= 1'b0;
              end
            end
            `FSW_CMD_VWREN: begin
              if (~pu_lock) begin
                vwel_q <= 1'b1;
              end
            end
            `FSW_CMD_WRDI: begin
              wel_q <= 1'b0; // [RULE24]
              vwel_q <= 1'b0;
            end
            `FSW_CMD_WRSR: begin
              // Refused writes leave every bit alone and never raise busy
              if (~pu_lock & (wel_q | vwel_q) & (byte_q >= 3'h2) & sr_open) begin // [RULE3] [RULE4] [RULE6] [RULE27]
                vol1_q <= merge(vol1_q, d1, `FSW_S1_WMASK); // [RULE9]
                if (has2) begin
                  vol2_q <= merge(vol2_q, d2, `FSW_S2_WMASK);
                end
                if (has3) begin
                  vol3_q <= merge(vol3_q, d3, `FSW_S3_WMASK);
                end
                if (wel_q) begin
                  nv1_q <= merge(nv1_q, d1, `FSW_S1_WMASK); // [RULE8] [RULE2]
                  if (has2) begin
                    nv2_q <= merge(nv2_q, d2, `FSW_S2_WMASK);
                    lb_q <= lb_q | d2[`FSW_S2_LB_HI:`FSW_S2_LB_LO]; // [RULE12] [RULE10]
                  end
                  if (has3) begin
                    nv3_q <= merge(nv3_q, d3, `FSW_S3_WMASK);
                  end
                  tw_busy_q <= 1'b1; // [RULE23]
                  tw_cnt_q <= 16'h0000;
                end
                wel_q <= 1'b0; // [RULE21]
                vwel_q <= 1'b0;
              end
            end
            `FSW_CMD_SUSP: begin
              if (susp_ok) begin
                sus_q <= 1'b1; // [RULE11]
                arr_busy_q <= 1'b0;
              end
            end
            `FSW_CMD_RESUME: begin
              if (sus_q) begin
                sus_q <= 1'b0; // [RULE11]
                arr_busy_q <= 1'b1;
              end
            end
            `FSW_CMD_PD: begin
              dpd_q <= 1'b1;
            end
            `FSW_CMD_RELPD: begin
              dpd_q <= 1'b0; // [RULE22]
            end
            `FSW_CMD_RSTEN: begin
              rst_en_q <= 1'b1;
            end
            `FSW_CMD_RST: begin
              if (rst_en_q) begin
                load_q <= 1'b1; // [RULE5]
              end
            end
            `FSW_CMD_PP, `FSW_CMD_SE, `FSW_CMD_BE, `FSW_CMD_CE: begin
              if (wel_q & ~pu_lock & arr_len_ok & ~sus_q & ~i_target_protected) begin // [RULE26]
                o_array_start <= 1'b1;
                o_array_cmd <= cmd_q;
                o_array_addr <= wd_q;
                arr_busy_q <= 1'b1; // [RULE23]
                wel_q <= 1'b0; // [RULE21] [RULE24]
              end
            end
            default: begin
              rst_en_q <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Registered status and pin-function outputs
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_status_one <= `FSW_S1_RESET;
      o_status_two <= `FSW_S2_RESET;
      o_status_three <= `FSW_S3_RESET;
      o_busy <= 1'b0;
      o_deep_power_down <= 1'b0;
      o_complement_protect <= 1'b0;
      o_top_bottom_select <= 1'b0;
      o_protect_scheme_sel <= 1'b0;
      o_quad_enable <= 1'b0;
      o_wp_pin_active <= 1'b1;
      o_pin_is_hold <= 1'b1;
      o_pin_is_reset <= 1'b0;
      o_drive_pct <= 7'd50;
      o_quad_high_freq_enable <= 1'b1;
      o_secreg_lock <= `FSW_LB_RESET;
    end else begin
      o_status_one <= eff1;
      o_status_two <= eff2;
      o_status_three <= eff3;
      o_busy <= busy;
      o_deep_power_down <= dpd_q;
      o_complement_protect <= vol2_q[`FSW_S2_CMP]; // [RULE1]
      o_top_bottom_select <= vol1_q[5]; // [RULE25]
      o_protect_scheme_sel <= vol3_q[`FSW_S3_WPS]; // [RULE17]
      o_quad_enable <= qe;
      o_wp_pin_active <= ~qe; // [RULE13]
      o_pin_is_hold <= ~qe & ~vol3_q[`FSW_S3_SHARED_PIN_FUNCTION_SEL]; // [RULE14]
      o_pin_is_reset <= ~qe & vol3_q[`FSW_S3_SHARED_PIN_FUNCTION_SEL];
      case (vol3_q[`FSW_S3_DRV_HI:`FSW_S3_DRV_LO]) // [RULE15]
        2'b00: o_drive_pct <= 7'd50;
        2'b01: o_drive_pct <= 7'd25;
        2'b10: o_drive_pct <= 7'd75;
        default: o_drive_pct <= 7'd100;
      endcase
      o_quad_high_freq_enable <= vol3_q[`FSW_S3_HFQ]; // [RULE16]
      o_secreg_lock <= lb_q; // [RULE12]
    end
  end

endmodule // fsw_status_protect

// File: fsw_status_protect_properties.sv
// Property checker for the flash status protection block
`timescale 1ns/10ps
module fsw_status_protect_properties (
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Watched outputs
  input wire o_array_start,
  input wire o_lock_init,
  input wire [7:0] o_status_three,
  input wire o_busy,
  input wire o_deep_power_down,
  input wire o_quad_enable,
  input wire o_wp_pin_active,
  input wire o_pin_is_hold,
  input wire [6:0] o_drive_pct,
  input wire o_quad_high_freq_enable,
  input wire [2:0] o_secreg_lock
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // Reset release, then a single-cycle pulse
  sequence s_release;
    $fell(i_reset);
  endsequence
  sequence s_init_pulse;
    o_lock_init ##1 !o_lock_init;
  endsequence
  lock_init_a: assert property (s_release |-> ##[1:4] s_init_pulse)
    else $error("lock init pulse missing");
  wp_pin_a: assert property (o_wp_pin_active == !o_quad_enable)
    else $error("protect pin function wrong");
  hold_pin_a: assert property (
    o_pin_is_hold == (!o_quad_enable && !o_status_three[7]))
    else $error("hold function wrong");
  drive_map_a: assert property (o_drive_pct == (
    o_status_three[6] ? (o_status_three[5] ? 7'h64 : 7'h4B) : (o_status_three[5] ? 7'h19 : 7'h32)))
    else $error("drive strength wrong");
  hfq_map_a: assert property (o_quad_high_freq_enable == o_status_three[4])
    else $error("high frequency bit wrong");
  lock_sticky_a: assert property (
    (o_secreg_lock & $past(o_secreg_lock)) == $past(o_secreg_lock))
    else $error("security lock bit cleared");
  array_busy_a: assert property (o_array_start |-> ##[0:2] o_busy)
    else $error("busy missing after array start");
  dpd_quiet_a: assert property (o_deep_power_down |-> !o_array_start)
    else $error("array start in power-down");
endmodule // fsw_status_protect_properties

bind fsw_status_protect fsw_status_protect_properties chk (
  .i_clk(i_clk), .i_reset(i_reset), .o_array_start(o_array_start), .o_lock_init(o_lock_init),
  .o_status_three(o_status_three), .o_busy(o_busy), .o_deep_power_down(o_deep_power_down),
  .o_quad_enable(o_quad_enable), .o_wp_pin_active(o_wp_pin_active), .o_pin_is_hold(o_pin_is_hold),
  .o_drive_pct(o_drive_pct), .o_quad_high_freq_enable(o_quad_high_freq_enable),
  .o_secreg_lock(o_secreg_lock)
);

// File: fsw_spi_host.sv
// Serial host model that sends mode 0 command frames
`timescale 1ns/10ps
module fsw_spi_host (
  // Serial link pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi,
  input wire logic i_miso
);
  // Idle link: deselected, clock parked low
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b1;
  end
  // Send nbits MSB first; rd keeps the last 8 bits read back
  task automatic frame(input logic [31:0] data, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    #13 o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_mosi = data[nbits-1-i];
      #32 o_sclk = 1'b1;
      rd = {rd[6:0], i_miso};
      #32 o_sclk = 1'b0;
    end
    #32 o_cs_n = 1'b1; // Deselect right after the last bit
    o_mosi = ~o_mosi; // Released line never shows a stale level
    #64;
  endtask
endmodule // fsw_spi_host

// File: fsw_status_protect_bench.sv
// Self-checking bench for the flash status protection block
`timescale 1ns/10ps
`include "fsw_defines.vh"
module fsw_status_protect_bench;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_wp_n = 1'b1;
  logic i_target_protected = 1'b0;
  logic i_array_done = 1'b0;
  wire cs_n, sclk, mosi, miso, oe_n, busy, deep_power_down, cmp, protect_scheme_sel, qe, wpa, hold, rfn, quad_high_freq_enable, init, tbs, ast;
  wire [7:0] s1, s2, s3, acmd;
  wire [23:0] addr;
  wire [6:0] drv;
  wire [2:0] lck;
  logic [7:0] rd;
  int error_cnt = 0;
  int checks = 0;
  int inits = 0;
  int starts = 0;
  // Clock and count of lock-init pulses
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) if (init === 1'b1) inits++;
  // Count of accepted array operations
  always @(posedge i_clk) if (ast === 1'b1) starts++;
  // Device under test
  fsw_status_protect uut (
    .i_clk(i_clk), .i_reset(i_reset), .i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi),
    .i_wp_n(i_wp_n), .o_miso(miso), .o_miso_oe_n(oe_n), .i_target_protected(i_target_protected),
    .i_array_done(i_array_done), .o_array_start(ast), .o_array_cmd(acmd), .o_array_addr(addr),
    .o_lock_init(init), .o_status_one(s1), .o_status_two(s2), .o_status_three(s3), .o_busy(busy),
    .o_deep_power_down(deep_power_down), .o_complement_protect(cmp), .o_top_bottom_select(tbs),
    .o_protect_scheme_sel(protect_scheme_sel), .o_quad_enable(qe), .o_wp_pin_active(wpa), .o_pin_is_hold(hold),
    .o_pin_is_reset(rfn), .o_drive_pct(drv), .o_quad_high_freq_enable(quad_high_freq_enable), .o_secreg_lock(lck));
  // Host on the far side; the undriven data line is pulled high
  fsw_spi_host host (.o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi), .i_miso(oe_n ? 1'b1 : miso));
  // Compare one value against its expectation
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One frame, then time for the block to act on it
  task automatic cmd(input logic [31:0] data, input int nbits);
    host.frame(data, nbits, rd);
    repeat (8) @(negedge i_clk);
  endtask
  // Wait for busy to drop, bounded
  task automatic wait_idle;
    for (int n = 0; n < 1500 && busy !== 1'b0; n++) @(negedge i_clk);
  endtask
  // Verdict and end of run
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung sequence
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
  // Test sequence
  initial begin
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
    check("s3", s3, 8'h10);
    check("hold", 8'(hold), 8'h01);
    cmd(32'h06, 8);
    check("s1", s1, 8'h00);
    repeat (`FSW_PUW_CYC) @(negedge i_clk);
    cmd(32'h06, 8);
    check("s1", s1, 8'h02);
    cmd(32'h04, 8);
    check("s1", s1, 8'h00);
    cmd(32'h06, 8);
    cmd(32'h01FFCA2F, 32);
    check("s1", s1, 8'hFD);
    wait_idle();
    check("s2", s2, 8'h4A);
    check("tbs", 8'(tbs), 8'h01);
    check("s3", s3, 8'h24);
    check("drv", 8'(drv), 8'h19);
    check("wpa", 8'(wpa), 8'h00);
    check("rfn", 8'(rfn), 8'h00);
    check("cmp", 8'(cmp), 8'h01);
    check("wps", 8'(protect_scheme_sel), 8'h01);
    check("lck", 8'(lck), 8'h01);
    cmd(32'h3500, 16);
    check("rd", rd, 8'h4A);
    cmd(32'h50, 8);
    cmd(32'h01FC78, 24);
    check("busy", 8'(busy), 8'h00);
    check("s2", s2, 8'h48);
    i_wp_n = 1'b0;
    cmd(32'h06, 8);
    cmd(32'h0100, 16);
    check("s1", s1, 8'hFE);
    i_wp_n = 1'b1;
    cmd(32'h010049, 24);
    wait_idle();
    check("s2", s2, 8'h49);
    cmd(32'h06, 8);
    cmd(32'h011C, 16);
    check("s1", s1, 8'h02);
    cmd(32'h66, 8);
    cmd(32'h99, 8);
    check("s2", s2, 8'h48);
    cmd(32'h06, 8);
    cmd(32'h01F, 12);
    check("s1", s1, 8'h02);
    cmd(32'h02123456, 32);
    check("acmd", acmd, 8'h02);
    check("addr", addr[15:8], 8'h34);
    check("s1", s1, 8'h01);
    cmd(32'h06, 8);
    check("s1", s1, 8'h01);
    cmd(32'h75, 8);
    check("s2", s2, 8'hC8);
    cmd(32'h7A, 8);
    check("s2", s2, 8'h48);
    i_array_done = 1'b1;
    @(negedge i_clk);
    i_array_done = 1'b0;
    repeat (4) @(negedge i_clk);
    check("busy", 8'(busy), 8'h00);
    cmd(32'h06, 8);
    i_target_protected = 1'b1;
    cmd(32'h20000000, 32);
    check("s1", s1, 8'h02);
    i_target_protected = 1'b0;
    cmd(32'hB9, 8);
    cmd(32'h04, 8);
    check("s1", s1, 8'h02);
    check("dpd", 8'(deep_power_down), 8'h01);
    cmd(32'hAB, 8);
    cmd(32'h04, 8);
    check("s1", s1, 8'h00);
    check("init", 8'(inits), 8'h02);
    check("starts", 8'(starts), 8'h01);
    cmd(32'h50, 8);
    cmd(32'h018001, 24);
    cmd(32'h50, 8);
    cmd(32'h0100, 16);
    check("s1", s1, 8'h80);
    complete_run();
  end
endmodule // fsw_status_protect_bench
